// file: eik_pkg.sv
// constants for the external request and key wakeup interrupt block
// assumes a 32-bit apb slave port and one 50 mhz clock
// How it works
// - both external request inputs use one vector pair at 3ffa and 3ffb
// - select 0: falling edge or low level sets flag; select 1: edge only
// - request raised for an external source while its flag and enable are set
// - request inputs share port c bits 7 and 6; levels readable there
// - pin-level branch instructions test only the first request input
// - eight key inputs on port b, each enabled, plus group enable
// - falling edge on an enabled key sets key flag; request when enabled
// - each key has its own fall latch; flag clear empties all eight
// - after enabling a pending source, request waits two instruction boundaries
// - the three timer 1 sources share vector 3ff6 and 3ff7
// - the two timer 2 sources share vector 3ff4 and 3ff5
// - serial transfer complete uses vector 3ff2 and 3ff3
// - timebase uses vector 3ff0 and 3ff1
// - control at 0008: enables 7,6,4, selects 3,2; others zero; resets zero
// - flags read-only; writing 1 to clear bit clears; clear bits read 0
// - system reset clears both external flags and the key flag
// - cpu mask bit gates all sources; masked requests stay latched
// - fixed priority: external, key, timer 1, timer 2, serial, timebase
package eik_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_KEYEN = 8'h10;
  localparam logic [7:0] ADDR_PINS = 8'h14;
  // control and status bit positions
  localparam int BIT_EN_A = 7;
  localparam int BIT_EN_B = 6;
  localparam int BIT_EN_KEY = 4;
  localparam int BIT_SEL_A = 3;
  localparam int BIT_SEL_B = 2;
  localparam int BIT_FLAG_A = 7;
  localparam int BIT_FLAG_B = 6;
  localparam int BIT_FLAG_KEY = 4;
  localparam int BIT_CLR_A = 3;
  localparam int BIT_CLR_B = 2;
  localparam int BIT_CLR_KEY = 0;
  // pin readback positions
  localparam int BIT_PIN_A = 7;
  localparam int BIT_PIN_B = 6;
  localparam int PIN_KEY_LSB = 8;
  // writable control bits and reset values
  localparam logic [7:0] CTRL_MASK = 8'hdc;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] KEYEN_RESET = 8'h00;
  localparam int NUM_KEYS = 8;
  // source index inside the three-entry delay arrays
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_KEY = 2;
  localparam int NUM_SRC = 3;
  // instruction boundaries to pass after an enable is set
  localparam logic [1:0] ENABLE_DELAY = 2'h2;
  // vector addresses, first byte of each pair
  localparam logic [13:0] VEC_EXT = 14'h3ffa;
  localparam logic [13:0] VEC_KEY = 14'h3ff8;
  localparam logic [13:0] VEC_TIMER_A = 14'h3ff6;
  localparam logic [13:0] VEC_TIMER_B = 14'h3ff4;
  localparam logic [13:0] VEC_SERIAL = 14'h3ff2;
  localparam logic [13:0] VEC_TIMEBASE = 14'h3ff0;
  localparam logic [13:0] VEC_NONE = 14'h0000;
endpackage : eik_pkg

// file: eik_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module eik_sync #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  // idle pins sit high, so reset to ones
  always_comb begin
    next_stage1 = pin_in;
    next_stage2 = stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '1;
      stage2 <= '1;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign level = stage2;
endmodule : eik_sync
`default_nettype wire

// file: eik_ctrl.sv
// external request and key wakeup interrupt controller with apb registers
// assumes apb master on pclk, pins asynchronous, cpu signals on pclk
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module eik_ctrl
  import eik_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins, active low requests
  input wire logic ext_request_a_n,
  input wire logic ext_request_b_n,
  input wire logic [7:0] key_wakeup_n,
  // port c data latches of bits 7 and 6
  input wire logic port_c_latch7,
  input wire logic port_c_latch6,
  // peripheral requests, already locally enabled
  input wire logic timer_a_overflow_int,
  input wire logic timer_a_capture_int,
  input wire logic timer_a_compare_int,
  input wire logic timer_b_event_int,
  input wire logic timer_b_compare_int,
  input wire logic simple_serial_port_int,
  input wire logic timebase_int,
  // cpu side
  input wire logic cpu_i_mask,
  input wire logic instr_done,
  output logic irq_request,
  output logic [13:0] irq_vector,
  output logic branch_pin_level
);

  // synchronised pins
  logic [9:0] pin_level;
  logic pin_a;
  logic pin_b;
  logic [7:0] key_pin;

  eik_sync #(.W(10)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({ext_request_a_n, ext_request_b_n, key_wakeup_n}),
    .level(pin_level)
  );

  assign pin_a = pin_level[9];
  assign pin_b = pin_level[8];
  assign key_pin = pin_level[7:0];

  // state
  logic [7:0] ctrl;
  logic [7:0] key_en;
  logic flag_a;
  logic flag_b;
  logic [7:0] key_latch;
  logic src_a_prev;
  logic src_b_prev;
  logic [7:0] key_prev;
  logic [1:0] delay_cnt [NUM_SRC];
  logic [31:0] rdata;
  logic req_out;
  logic [13:0] vec_out;
  logic pin_out;

  logic [7:0] next_ctrl;
  logic [7:0] next_key_en;
  logic next_flag_a;
  logic next_flag_b;
  logic [7:0] next_key_latch;
  logic [1:0] next_delay_cnt [NUM_SRC];
  logic [31:0] next_rdata;
  logic next_req_out;
  logic [13:0] next_vec_out;

  // bus decode
  logic setup;
  logic wr_access;
  logic [7:0] addr;
  logic mapped;
  logic lane0;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_keyen;

  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign addr = paddr[7:0];
  assign mapped = (paddr[31:8] == 24'h000000) &&
                  ((addr == ADDR_CTRL) || (addr == ADDR_STAT) ||
                   (addr == ADDR_KEYEN) || (addr == ADDR_PINS));
  assign lane0 = pstrb[0];
  assign wr_ctrl = wr_access & lane0 & (addr == ADDR_CTRL) & mapped;
  assign wr_stat = wr_access & lane0 & (addr == ADDR_STAT) & mapped;
  assign wr_keyen = wr_access & lane0 & (addr == ADDR_KEYEN) & mapped;

  // zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata;

  // request sources: pin low or port c latch low pulls the line
  logic src_a;
  logic src_b;
  logic fall_a;
  logic fall_b;
  logic [7:0] key_fall;
  logic clr_a;
  logic clr_b;
  logic clr_key;
  logic flag_key;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] src_req;
  logic [7:0] status;

  assign src_a = pin_a & port_c_latch7;
  assign src_b = pin_b & port_c_latch6;
  assign fall_a = src_a_prev & ~src_a;
  assign fall_b = src_b_prev & ~src_b;
  assign key_fall = key_prev & ~key_pin;

  assign clr_a = wr_stat & pwdata[BIT_CLR_A];
  assign clr_b = wr_stat & pwdata[BIT_CLR_B];
  assign clr_key = wr_stat & pwdata[BIT_CLR_KEY];

  assign flag_key = |key_latch;

  assign src_en[SRC_A] = ctrl[BIT_EN_A];
  assign src_en[SRC_B] = ctrl[BIT_EN_B];
  assign src_en[SRC_KEY] = ctrl[BIT_EN_KEY];
  assign src_flag[SRC_A] = flag_a;
  assign src_flag[SRC_B] = flag_b;
  assign src_flag[SRC_KEY] = flag_key;

  // status layout, clear bits read zero
  always_comb begin
    status = 8'h00;
    status[BIT_FLAG_A] = flag_a;
    status[BIT_FLAG_B] = flag_b;
    status[BIT_FLAG_KEY] = flag_key;
  end

  // flag set conditions, set wins over clear
  always_comb begin
    next_flag_a = flag_a;
    next_flag_b = flag_b;
    if (clr_a) begin
      next_flag_a = 1'b0;
    end
    if (clr_b) begin
      next_flag_b = 1'b0;
    end
    if (ctrl[BIT_SEL_A] ? fall_a : ~src_a) begin
      next_flag_a = 1'b1;
    end
    if (ctrl[BIT_SEL_B] ? fall_b : ~src_b) begin
      next_flag_b = 1'b1;
    end
  end

  // per key fall latches, one clear for all
  genvar k;
  generate
    for (k = 0; k < NUM_KEYS; k++) begin : g_key
      always_comb begin
        next_key_latch[k] = key_latch[k];
        if (clr_key) begin
          next_key_latch[k] = 1'b0;
        end
        if (key_en[k] & key_fall[k]) begin
          next_key_latch[k] = 1'b1;
        end
      end
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : g_src
      logic rising_en;
      assign rising_en = wr_ctrl & ~src_en[s] &
                         pwdata[(s == SRC_A) ? BIT_EN_A :
                                (s == SRC_B) ? BIT_EN_B : BIT_EN_KEY];
      always_comb begin
        next_delay_cnt[s] = delay_cnt[s];
        if (rising_en) begin
          next_delay_cnt[s] = ENABLE_DELAY;
        end else if (instr_done && (delay_cnt[s] != 2'h0)) begin
          next_delay_cnt[s] = delay_cnt[s] - 2'h1;
        end
      end
      assign src_req[s] = src_flag[s] & src_en[s] & (delay_cnt[s] == 2'h0);
    end
  endgenerate

  // control, key enable and read data
  always_comb begin
    next_ctrl = ctrl;
    next_key_en = key_en;
    next_rdata = rdata;
    if (wr_ctrl) begin
      next_ctrl = pwdata[7:0] & CTRL_MASK;
    end
    if (wr_keyen) begin
      next_key_en = pwdata[7:0];
    end
    if (setup && !pwrite) begin
      next_rdata = 32'h00000000;
      unique case (addr)
        ADDR_CTRL: next_rdata[7:0] = ctrl;
        ADDR_STAT: next_rdata[7:0] = status;
        ADDR_KEYEN: next_rdata[7:0] = key_en;
        ADDR_PINS: begin
          next_rdata[BIT_PIN_A] = pin_a;
          next_rdata[BIT_PIN_B] = pin_b;
          next_rdata[PIN_KEY_LSB +: NUM_KEYS] = key_pin;
        end
        default: next_rdata = 32'h00000000;
      endcase
      if (paddr[31:8] != 24'h000000) begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always_comb begin
    next_vec_out = VEC_NONE;
    if (src_req[SRC_A] | src_req[SRC_B]) begin
      next_vec_out = VEC_EXT;
    end else if (src_req[SRC_KEY]) begin
      next_vec_out = VEC_KEY;
    end else if (timer_a_overflow_int | timer_a_capture_int | timer_a_compare_int) begin
      next_vec_out = VEC_TIMER_A;
    end else if (timer_b_event_int | timer_b_compare_int) begin
      next_vec_out = VEC_TIMER_B;
    end else if (simple_serial_port_int) begin
      next_vec_out = VEC_SERIAL;
    end else if (timebase_int) begin
      next_vec_out = VEC_TIMEBASE;
    end
    next_req_out = (next_vec_out != VEC_NONE) & ~cpu_i_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      key_en <= KEYEN_RESET;
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      key_latch <= 8'h00;
      src_a_prev <= 1'b1;
      src_b_prev <= 1'b1;
      key_prev <= 8'hff;
      for (int i = 0; i < NUM_SRC; i++) begin
        delay_cnt[i] <= 2'h0;
      end
      rdata <= 32'h00000000;
      req_out <= 1'b0;
      vec_out <= VEC_NONE;
      pin_out <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      key_en <= next_key_en;
      flag_a <= next_flag_a;
      flag_b <= next_flag_b;
      key_latch <= next_key_latch;
      src_a_prev <= src_a;
      src_b_prev <= src_b;
      key_prev <= key_pin;
      for (int i = 0; i < NUM_SRC; i++) begin
        delay_cnt[i] <= next_delay_cnt[i];
      end
      rdata <= next_rdata;
      req_out <= next_req_out;
      vec_out <= next_vec_out;
      pin_out <= pin_a;
    end
  end

  assign irq_request = req_out;
  assign irq_vector = vec_out;
  assign branch_pin_level = pin_out;

endmodule : eik_ctrl
`default_nettype wire

// file: eik_pins_model.sv
// far side: request pins and key pins of eik_ctrl
// assumes the bench calls drive just after a rising pclk edge
`timescale 1ns/1ns
`default_nettype none
module eik_pins_model (
  // pins, low means asserted
  output logic pin_a_n,
  output logic pin_b_n,
  output logic [7:0] key_n
);
  initial {pin_a_n, pin_b_n, key_n} = 10'h3ff;
  // set all ten pin levels at once
  task automatic drive(input logic [9:0] v);
    {pin_a_n, pin_b_n, key_n} <= v;
  endtask : drive
endmodule : eik_pins_model
`default_nettype wire

// file: eik_ctrl_assertions.sv
// port assertions for eik_ctrl
// assumes timer inputs are held low while in reset
`timescale 1ns/1ns
`default_nettype none
module eik_ctrl_assertions
  import eik_pkg::*;
(
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  // sources and cpu side
  input wire logic ext_request_a_n,
  input wire logic timer_a_overflow_int,
  input wire logic timer_b_event_int,
  input wire logic simple_serial_port_int,
  input wire logic timebase_int,
  input wire logic cpu_i_mask,
  input wire logic irq_request,
  input wire logic [13:0] irq_vector,
  input wire logic branch_pin_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read access cycles
  logic rd_c;
  logic rd_s;
  assign rd_c = psel && penable && !pwrite && paddr == {24'h0, ADDR_CTRL};
  assign rd_s = psel && penable && !pwrite && paddr == {24'h0, ADDR_STAT};
  property p_mask;
    $stable(cpu_i_mask) |-> irq_request == (irq_vector != VEC_NONE && !cpu_i_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("request vs mask");
  property p_ta;
    $past(timer_a_overflow_int) |-> irq_vector >= VEC_TIMER_A;
  endproperty
  a_ta: assert property (p_ta) else $error("timer 1 vector");
  property p_tb;
    $past(timer_b_event_int) |-> irq_vector >= VEC_TIMER_B;
  endproperty
  a_tb: assert property (p_tb) else $error("timer 2 vector");
  property p_ser;
    $past(simple_serial_port_int) |-> irq_vector >= VEC_SERIAL;
  endproperty
  a_ser: assert property (p_ser) else $error("serial vector");
  property p_tbase;
    $past(timebase_int) |-> irq_vector >= VEC_TIMEBASE;
  endproperty
  a_tbase: assert property (p_tbase) else $error("timebase vector");
  property p_pin;
    $stable(ext_request_a_n) [*5] |-> branch_pin_level == ext_request_a_n;
  endproperty
  a_pin: assert property (p_pin) else $error("branch level");
  property p_rst;
    $past(presetn) == 1'h0 |-> irq_vector == VEC_NONE && branch_pin_level;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_crd;
    rd_c |-> prdata[5] == 1'h0 && prdata[1:0] == 2'h0;
  endproperty
  a_crd: assert property (p_crd) else $error("control reserved");
  property p_srd;
    rd_s |-> prdata[5] == 1'h0 && prdata[3:0] == 4'h0;
  endproperty
  a_srd: assert property (p_srd) else $error("status clear bits");
  // main scenarios reached
  c_irq: cover property ($rose(irq_request));
  c_ext: cover property (irq_vector == VEC_EXT);
  c_key: cover property (irq_vector == VEC_KEY);
endmodule : eik_ctrl_assertions
bind eik_ctrl eik_ctrl_assertions eik_ctrl_assertions_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .ext_request_a_n,
  .timer_a_overflow_int, .timer_b_event_int, .simple_serial_port_int, .timebase_int,
  .cpu_i_mask, .irq_request, .irq_vector, .branch_pin_level
);
`default_nettype wire

// file: eik_ctrl_test.sv
// self-checking bench for eik_ctrl over apb
// assumes eik_pins_model drives pins, bench drives the rest
`timescale 1ns/1ns
`default_nettype none
module eik_ctrl_test
  import eik_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq, bpl, a_n, b_n;
  logic pc7 = 1'h1, pc6 = 1'h1, mask = 1'h1, idone = 1'h0;
  logic [6:0] per = 7'h0;
  logic [7:0] key_n;
  logic [13:0] vec;
  int n_errors = 0;
  int n_compared = 0;
  // block and far side
  eik_ctrl eik_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_a_n(a_n), .ext_request_b_n(b_n),
    .key_wakeup_n(key_n), .port_c_latch7(pc7), .port_c_latch6(pc6),
    .timer_a_overflow_int(per[0]), .timer_a_capture_int(per[1]),
    .timer_a_compare_int(per[2]), .timer_b_event_int(per[3]),
    .timer_b_compare_int(per[4]), .simple_serial_port_int(per[5]),
    .timebase_int(per[6]), .cpu_i_mask(mask), .instr_done(idone), .irq_request(irq),
    .irq_vector(vec), .branch_pin_level(bpl));
  eik_pins_model eik_pins_model_inst (.pin_a_n(a_n), .pin_b_n(b_n), .key_n(key_n));
  // 50 mhz clock
  always #10 pclk = ~pclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // only the watchdog ends a wait that never gets pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic ci(input logic e, input logic [13:0] v);
    chk({31'h0, irq}, {31'h0, e});
    chk({18'h0, vec}, {18'h0, v});
  endtask : ci
  task automatic pins(input logic [9:0] v);
    eik_pins_model_inst.drive(v);
    cyc(6);
  endtask : pins
  // one instruction boundary
  task automatic step();
    @(posedge pclk);
    idone <= 1'h1;
    @(posedge pclk);
    idone <= 1'h0;
    cyc(2);
  endtask : step
  function automatic logic [13:0] pv(input int i);
    return i == 6 ? VEC_TIMEBASE : i == 5 ? VEC_SERIAL : i > 2 ? VEC_TIMER_B : VEC_TIMER_A;
  endfunction : pv
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    cyc(5000);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    cyc(6);
    presetn <= 1'h1;
    cyc(3);
    rc(ADDR_CTRL, 32'h0);
    rc(ADDR_STAT, 32'h0);
    rc(ADDR_KEYEN, 32'h0);
    wr(ADDR_CTRL, 32'hff);
    rc(ADDR_CTRL, 32'hdc);
    rc(8'h04, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    mask <= 1'h0;
    pins(10'h1ff);
    wr(ADDR_STAT, 32'h08);
    rc(ADDR_STAT, 32'h80);
    wr(ADDR_CTRL, 32'h80);
    step();
    ci(1'h0, VEC_NONE);
    step();
    ci(1'h1, VEC_EXT);
    mask <= 1'h1;
    cyc(3);
    ci(1'h0, VEC_EXT);
    mask <= 1'h0;
    pins(10'h3ff);
    wr(ADDR_STAT, 32'h0);
    ci(1'h1, VEC_EXT);
    wr(ADDR_STAT, 32'h08);
    rc(ADDR_STAT, 32'h0);
    wr(ADDR_CTRL, 32'h0c);
    pins(10'h1ff);
    rc(ADDR_STAT, 32'h80);
    wr(ADDR_STAT, 32'h08);
    rc(ADDR_STAT, 32'h0);
    rc(ADDR_PINS, 32'hff40);
    chk({31'h0, bpl}, 32'h0);
    pins(10'h2ff);
    rc(ADDR_PINS, 32'hff80);
    chk({31'h0, bpl}, 32'h1);
    rc(ADDR_STAT, 32'h40);
    wr(ADDR_STAT, 32'h04);
    rc(ADDR_STAT, 32'h0);
    pins(10'h3ff);
    wr(ADDR_STAT, 32'h04);
    rc(ADDR_STAT, 32'h0);
    pc7 <= 1'h0;
    pc6 <= 1'h0;
    cyc(4);
    rc(ADDR_STAT, 32'hc0);
    pc7 <= 1'h1;
    pc6 <= 1'h1;
    wr(ADDR_STAT, 32'h0c);
    rc(ADDR_STAT, 32'h0);
    wr(ADDR_KEYEN, 32'h01);
    wr(ADDR_CTRL, 32'h10);
    pins(10'h3fd);
    rc(ADDR_STAT, 32'h0);
    pins(10'h3fc);
    rc(ADDR_STAT, 32'h10);
    step();
    step();
    ci(1'h1, VEC_KEY);
    per <= 7'h01;
    cyc(3);
    ci(1'h1, VEC_KEY);
    per <= 7'h0;
    wr(ADDR_STAT, 32'h01);
    rc(ADDR_STAT, 32'h0);
    pins(10'h3ff);
    wr(ADDR_KEYEN, 32'h03);
    pins(10'h3fc);
    rc(ADDR_STAT, 32'h10);
    wr(ADDR_STAT, 32'h01);
    rc(ADDR_STAT, 32'h0);
    pins(10'h3ff);
    wr(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 7; i++) begin
      per <= 7'h1 << i;
      cyc(3);
      ci(1'h1, pv(i));
    end
    end_of_test();
  end
endmodule : eik_ctrl_test
`default_nettype wire
